// File: src/sec_pkg.sv
package sec_pkg;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_NS = 20;
	localparam int PROG_X8_NS = 1000000;
	localparam int PROG_X16_NS = 2000000;
	localparam int PROG_ALL_NS = 15000000;
	localparam int PROG_X8_CYC = PROG_X8_NS / CLK_NS;
	localparam int PROG_X16_CYC = PROG_X16_NS / CLK_NS;
	localparam int PROG_ALL_CYC = PROG_ALL_NS / CLK_NS;
	localparam int SCLK_HALF_NS = 250;
	localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
	localparam int CS_LOW_NS = 100;
	localparam int CS_LOW_CYC = (CS_LOW_NS + CLK_NS - 1) / CLK_NS;
	// ------------------------------------------------------------
	// Organisation and instruction coding
	// ------------------------------------------------------------
	localparam int AW_X16 = 8;
	localparam int AW_X8 = 9;
	localparam int DW_X16 = 16;
	localparam int DW_X8 = 8;
	localparam int ADDR_BITS_SMALL = 8;
	localparam logic [1:0] OP_EXT = 2'h0;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_READ = 2'h2;
	localparam logic [1:0] OP_ERASE = 2'h3;
	localparam logic [1:0] EXT_DIS = 2'h0;
	localparam logic [1:0] EXT_WRALL = 2'h1;
	localparam logic [1:0] EXT_ERALL = 2'h2;
	localparam logic [1:0] EXT_EN = 2'h3;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;
	typedef enum logic [2:0] {
		DEV_IDLE = 3'h0,
		DEV_CMD = 3'h1,
		DEV_WDATA = 3'h2,
		DEV_READ = 3'h3,
		DEV_DONE = 3'h4
	} sec_dev_state_t;
	typedef enum logic [2:0] {
		PEND_NONE = 3'h0,
		PEND_ERASE = 3'h1,
		PEND_WRITE = 3'h2,
		PEND_ERASE_ALL_CMD = 3'h3,
		PEND_WRITE_ALL_CMD = 3'h4
	} sec_pend_t;
	typedef enum logic [2:0] {
		H_IDLE = 3'h0,
		H_GAP = 3'h1,
		H_LOW = 3'h2,
		H_HIGH = 3'h3,
		H_POLL = 3'h4
	} sec_host_state_t;
	// ------------------------------------------------------------
	// Controller registers
	// ------------------------------------------------------------
	localparam int AXI_AW = 8;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_TXDATA = 8'h04;
	localparam logic [7:0] REG_RXDATA = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
	localparam int CTRL_LEN_LSB = 0;
	localparam int CTRL_LEN_W = 6;
	localparam int CTRL_POLL_BIT = 8;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_LINE_BIT = 1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: src/sec_link_if.sv
`timescale 1ns/1ns
`default_nettype none
interface sec_link_if;
	logic cs;
	logic sclk;
	logic sdi;
	logic sdo_out;
	logic sdo_oe;
	logic org_val;
	logic org_oe;
	logic sdo;
	logic org;
	// Pull-ups: idle data-out reads high, floating org selects x16
	assign sdo = sdo_oe ? sdo_out : 1'h1;
	assign org = org_oe ? org_val : 1'h1;
	modport dev (input cs, input sclk, input sdi, input org,
		output sdo_out, output sdo_oe);
	modport ctl (output cs, output sclk, output sdi, input sdo);
endinterface
`default_nettype wire

// File: src/sec_edge.sv
`timescale 1ns/1ns
`default_nettype none
module sec_edge (
	input wire logic mclk,
	input wire logic rst,
	input wire logic level,
	output logic rise,
	output logic fall
);
	import sec_pkg::*;
	logic last;
	logic next_last;
	always_comb begin
		next_last = level;
	end
	always_ff @(posedge mclk) begin
		if (rst) begin
			last <= 1'h0;
		end else begin
			last <= next_last;
		end
	end
	assign rise = level & ~last;
	assign fall = ~level & last;
endmodule
`default_nettype wire

// File: src/sec_device.sv
// Contract
// - Org high or floating is x16, low x8
// - Sample input bits on serial clock rise
// - Data out floats except read or status
// - Status low while busy, high when ready
// - Status output ends on serial clock fall
// - Start bit: select and data high
// - Nothing happens before a start bit
// - Select high leaves standby at once
// - Execute only after all bits clocked; a write or write-all commits even if its data bits are cut short
// - After last bit, ignore clock and data
// - Programming disabled after reset; enable first
// - Read gives dummy zero then word
// - Read bits change on serial clock rise
// - Held select keeps reading next addresses
// - Small x16: seven-bit address, 27/11 clocks
// - Small x8: eight-bit address, 20/12 clocks
// - Large part: eight or nine address bits
// - Opcode 00 decoded by two address bits
// - Select fall after command starts programming
// - Select low resets all but programming
//
// The AXI4-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/1ns
`default_nettype none
module sec_device #(
	parameter int ADDR_BITS = sec_pkg::ADDR_BITS_SMALL,
	parameter int PROG_X8_CYC = sec_pkg::PROG_X8_CYC,
	parameter int PROG_X16_CYC = sec_pkg::PROG_X16_CYC,
	parameter int PROG_ALL_CYC = sec_pkg::PROG_ALL_CYC
) (
	input wire logic mclk,
	input wire logic rst,
	sec_link_if.dev link,
	output logic busy,
	output logic prog_enabled
);
	import sec_pkg::*;
	localparam int MEM_BYTES = 1 << ADDR_BITS;
	localparam logic [8:0] MASK_X8 = 9'(MEM_BYTES - 1);
	localparam logic [8:0] MASK_X16 = 9'(MEM_BYTES / 2 - 1);
	localparam int TW = 20;

	logic [7:0] mem [0:MEM_BYTES-1];
	sec_dev_state_t state, next_state;
	sec_pend_t pend, next_pend;
	logic [4:0] cnt, next_cnt;
	logic [10:0] sr, next_sr;
	logic [15:0] wd, next_wd;
	logic [8:0] addr, next_addr;
	logic [15:0] dout, next_dout;
	logic sdo_q, next_sdo;
	logic oe_q, next_oe;
	logic stat, next_stat;
	logic started, next_started;
	logic next_busy, next_prog_en;
	logic [TW-1:0] timer, next_timer;
	logic commit;
	logic cs_rise, cs_fall, sclk_rise, sclk_fall;
	logic x16;
	logic [4:0] aw, dw;
	logic [8:0] amask, afield, ia, ib;
	logic [10:0] full;
	logic [1:0] opc, ext;
	logic [15:0] rdw;
	logic [7:0] hi_byte;
	int pcyc;

	// ------------------------------------------------------------
	// Pin edges
	// ------------------------------------------------------------
	sec_edge u_cs_edge (
		.mclk(mclk),
		.rst(rst),
		.level(link.cs),
		.rise(cs_rise),
		.fall(cs_fall)
	);
	sec_edge u_sclk_edge (
		.mclk(mclk),
		.rst(rst),
		.level(link.sclk),
		.rise(sclk_rise),
		.fall(sclk_fall)
	);

	// ------------------------------------------------------------
	// Organisation and field extraction
	// ------------------------------------------------------------
	assign x16 = link.org;
	assign aw = x16 ? 5'(AW_X16) : 5'(AW_X8);
	assign dw = x16 ? 5'(DW_X16) : 5'(DW_X8);
	// Part size drops the top address bit on the small part
	assign amask = x16 ? MASK_X16 : MASK_X8;
	assign full = {sr[9:0], link.sdi};
	assign opc = x16 ? full[9:8] : full[10:9];
	assign afield = x16 ? {1'h0, full[7:0]} : full[8:0];
	assign ext = x16 ? full[7:6] : full[8:7];
	assign ia = x16 ? {addr[7:0], 1'h0} : addr;
	assign ib = x16 ? {addr[7:0], 1'h1} : addr;
	assign rdw = x16 ? {mem[ia[ADDR_BITS-1:0]], mem[ib[ADDR_BITS-1:0]]}
		: {mem[ia[ADDR_BITS-1:0]], 8'h00};
	assign hi_byte = x16 ? wd[15:8] : wd[7:0];
	assign pcyc = (pend == PEND_ERASE_ALL_CMD || pend == PEND_WRITE_ALL_CMD) ? PROG_ALL_CYC
		: (x16 ? PROG_X16_CYC : PROG_X8_CYC);

	// ------------------------------------------------------------
	// Command engine
	// ------------------------------------------------------------
	always_comb begin
		next_state = state;
		next_pend = pend;
		next_cnt = cnt;
		next_sr = sr;
		next_wd = wd;
		next_addr = addr;
		next_dout = dout;
		next_sdo = sdo_q;
		next_oe = oe_q;
		next_stat = stat;
		next_started = started;
		next_busy = busy;
		next_prog_en = prog_enabled;
		next_timer = timer;
		commit = 1'h0;
		if (busy) begin
			if (timer == '0) begin
				next_busy = 1'h0;
			end else begin
				next_timer = timer - 1'h1;
			end
		end
		if (!link.cs) begin
			// Deselected: control held in reset, timer keeps running
			next_state = DEV_IDLE;
			next_cnt = 5'h00;
			next_pend = PEND_NONE;
			next_stat = 1'h0;
			next_oe = 1'h0;
			// An enabled command commits once its address is clocked, even if write data bits are cut short
			if (cs_fall && pend != PEND_NONE && prog_enabled && !busy) begin
				commit = 1'h1;
				next_busy = 1'h1;
				next_timer = TW'(pcyc - 1);
				next_started = 1'h1;
			end
		end else begin
			// Awake as soon as select is high
			if (cs_rise && started) begin
				next_stat = 1'h1;
				next_started = 1'h0;
			end
			if (sclk_fall && stat) begin
				next_stat = 1'h0;
				next_oe = 1'h0;
			end
			if (sclk_rise) begin
				case (state)
				DEV_IDLE: begin
					if (link.sdi) begin
						next_state = DEV_CMD;
						next_cnt = 5'h00;
					end
				end
				DEV_CMD: begin
					next_sr = full;
					next_cnt = cnt + 5'h01;
					if (cnt == aw + 5'h01) begin
						next_addr = afield & amask;
						next_cnt = 5'h00;
						next_state = DEV_DONE;
						case (opc)
						OP_READ: begin
							next_state = DEV_READ;
							next_sdo = 1'h0;
							next_oe = 1'h1;
							next_cnt = dw;
						end
						OP_WRITE: begin
							next_pend = PEND_WRITE;
							next_state = DEV_WDATA;
						end
						OP_ERASE: begin
							next_pend = PEND_ERASE;
						end
						default: begin
							case (ext)
							EXT_EN: next_prog_en = 1'h1;
							EXT_DIS: next_prog_en = 1'h0;
							EXT_ERALL: next_pend = PEND_ERASE_ALL_CMD;
							default: begin
								next_pend = PEND_WRITE_ALL_CMD;
								next_state = DEV_WDATA;
							end
							endcase
						end
						endcase
					end
				end
				DEV_WDATA: begin
					next_wd = {wd[14:0], link.sdi};
					next_cnt = cnt + 5'h01;
					if (cnt == dw - 5'h01) begin
						next_state = DEV_DONE;
					end
				end
				DEV_READ: begin
					// Word boundary reloads from the advanced address
					if (cnt == dw) begin
						next_sdo = rdw[15];
						next_dout = {rdw[14:0], 1'h0};
						next_cnt = 5'h01;
					end else begin
						next_sdo = dout[15];
						next_dout = {dout[14:0], 1'h0};
						next_cnt = cnt + 5'h01;
						if (cnt == dw - 5'h01) begin
							next_addr = (addr + 9'h001) & amask;
						end
					end
				end
				DEV_DONE: begin
					next_state = DEV_DONE;
				end
				default: begin
					next_state = DEV_IDLE;
				end
				endcase
			end
			if (next_stat) begin
				next_oe = 1'h1;
				next_sdo = ~next_busy;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			state <= DEV_IDLE;
			pend <= PEND_NONE;
			cnt <= 5'h00;
			sr <= 11'h000;
			wd <= 16'h0000;
			addr <= 9'h000;
			dout <= 16'h0000;
			sdo_q <= 1'h0;
			oe_q <= 1'h0;
			stat <= 1'h0;
			started <= 1'h0;
			busy <= 1'h0;
			prog_enabled <= 1'h0;
			timer <= '0;
		end else begin
			state <= next_state;
			pend <= next_pend;
			cnt <= next_cnt;
			sr <= next_sr;
			wd <= next_wd;
			addr <= next_addr;
			dout <= next_dout;
			sdo_q <= next_sdo;
			oe_q <= next_oe;
			stat <= next_stat;
			started <= next_started;
			busy <= next_busy;
			prog_enabled <= next_prog_en;
			timer <= next_timer;
		end
	end

	// ------------------------------------------------------------
	// Array; content applied at start, busy models the cycle
	// ------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (commit) begin
			case (pend)
			PEND_ERASE: begin
				mem[ia[ADDR_BITS-1:0]] <= ERASED_BYTE;
				mem[ib[ADDR_BITS-1:0]] <= ERASED_BYTE;
			end
			PEND_WRITE: begin
				mem[ia[ADDR_BITS-1:0]] <= hi_byte;
				mem[ib[ADDR_BITS-1:0]] <= wd[7:0];
			end
			PEND_ERASE_ALL_CMD: begin
				for (int i = 0; i < MEM_BYTES; i++) begin
					mem[i] <= ERASED_BYTE;
				end
			end
			PEND_WRITE_ALL_CMD: begin
				// Write-all only clears bits: no erase first
				for (int i = 0; i < MEM_BYTES; i++) begin
					mem[i] <= mem[i] & ((x16 && i % 2 == 0) ? wd[15:8] : wd[7:0]);
				end
			end
			default: begin
			end
			endcase
		end
	end

	assign link.sdo_out = sdo_q;
	assign link.sdo_oe = oe_q;
endmodule
`default_nettype wire

// File: src/sec_host.sv
`timescale 1ns/1ns
`default_nettype none
module sec_host #(
	parameter int HALF_CYC = sec_pkg::SCLK_HALF_CYC,
	parameter int GAP_CYC = sec_pkg::CS_LOW_CYC
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [sec_pkg::AXI_AW-1:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	input wire logic [sec_pkg::AXI_AW-1:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready,
	sec_link_if.ctl link
);
	import sec_pkg::*;
	localparam int DW = 8;

	// ------------------------------------------------------------
	// AXI4-Lite slave
	// ------------------------------------------------------------
	logic [AXI_AW-1:0] wa, next_wa;
	logic [31:0] wv, next_wv, tx_reg, next_tx_reg;
	logic aw_got, next_aw_got, w_got, next_w_got;
	logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
	logic [1:0] next_bresp, next_rresp;
	logic [31:0] next_rdata;
	logic [8:0] ctrl, next_ctrl;
	logic go;
	// Engine state
	sec_host_state_t hs, next_hs;
	logic [DW-1:0] tick_cnt, next_tick_cnt;
	logic [5:0] bits, next_bits;
	logic [31:0] tx, next_tx, rx, next_rx;
	logic cs_q, next_cs, sclk_q, next_sclk, sdi_q, next_sdi;
	logic tick;

	always_comb begin
		next_wa = wa;
		next_wv = wv;
		next_aw_got = aw_got;
		next_w_got = w_got;
		next_awready = s_awready;
		next_wready = s_wready;
		next_bvalid = s_bvalid;
		next_bresp = s_bresp;
		next_arready = s_arready;
		next_rvalid = s_rvalid;
		next_rdata = s_rdata;
		next_rresp = s_rresp;
		next_tx_reg = tx_reg;
		next_ctrl = ctrl;
		go = 1'h0;
		if (s_awvalid && s_awready) begin
			next_wa = s_awaddr;
			next_aw_got = 1'h1;
			next_awready = 1'h0;
		end
		if (s_wvalid && s_wready) begin
			next_wv = s_wdata;
			next_w_got = 1'h1;
			next_wready = 1'h0;
		end
		if (aw_got && w_got && !s_bvalid) begin
			next_bvalid = 1'h1;
			next_bresp = RESP_OKAY;
			case (wa)
			REG_CTRL: begin
				// Ignored while a frame runs
				if (hs == H_IDLE) begin
					next_ctrl = wv[8:0];
					go = 1'h1;
				end
			end
			REG_TXDATA: next_tx_reg = wv;
			REG_RXDATA, REG_STATUS: begin
			end
			default: next_bresp = RESP_SLVERR;
			endcase
		end
		if (s_bvalid && s_bready) begin
			next_bvalid = 1'h0;
			next_aw_got = 1'h0;
			next_w_got = 1'h0;
			next_awready = 1'h1;
			next_wready = 1'h1;
		end
		if (s_arvalid && s_arready) begin
			next_arready = 1'h0;
			next_rvalid = 1'h1;
			next_rresp = RESP_OKAY;
			case (s_araddr)
			REG_CTRL: next_rdata = {23'h000000, ctrl};
			REG_TXDATA: next_rdata = tx_reg;
			REG_RXDATA: next_rdata = rx;
			REG_STATUS: next_rdata = {30'h00000000, link.sdo, hs != H_IDLE};
			default: begin
				next_rdata = 32'h00000000;
				next_rresp = RESP_SLVERR;
			end
			endcase
		end
		if (s_rvalid && s_rready) begin
			next_rvalid = 1'h0;
			next_arready = 1'h1;
		end
	end

	// ------------------------------------------------------------
	// Serial engine: sclk half period from a divider enable
	// ------------------------------------------------------------
	assign tick = (tick_cnt == DW'(HALF_CYC - 1));

	always_comb begin
		next_hs = hs;
		next_tick_cnt = tick ? '0 : tick_cnt + 1'h1;
		next_bits = bits;
		next_tx = tx;
		next_rx = rx;
		next_cs = cs_q;
		next_sclk = sclk_q;
		next_sdi = sdi_q;
		case (hs)
		H_IDLE: begin
			next_tick_cnt = '0;
			if (go) begin
				next_hs = H_GAP;
				next_tx = tx_reg;
				next_bits = 6'h00;
			end
		end
		H_GAP: begin
			// Guarantees select low time between instructions
			if (tick_cnt == DW'(GAP_CYC - 1)) begin
				next_tick_cnt = '0;
				next_cs = 1'h1;
				next_hs = ctrl[CTRL_POLL_BIT] ? H_POLL : H_LOW;
				next_sdi = tx[31];
			end
		end
		H_LOW: begin
			if (tick) begin
				next_sclk = 1'h1;
				next_bits = bits + 6'h01;
				next_hs = H_HIGH;
			end
		end
		H_HIGH: begin
			if (tick) begin
				// Sampled at the fall, clear of the output delay
				next_sclk = 1'h0;
				next_rx = {rx[30:0], link.sdo};
				if (bits == ctrl[CTRL_LEN_W-1:0]) begin
					next_cs = 1'h0;
					next_sdi = 1'h0;
					next_hs = H_IDLE;
				end else begin
					next_tx = {tx[30:0], 1'h0};
					next_sdi = tx[30];
					next_hs = H_LOW;
				end
			end
		end
		H_POLL: begin
			if (tick && link.sdo) begin
				next_cs = 1'h0;
				next_hs = H_IDLE;
			end
		end
		default: next_hs = H_IDLE;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			wa <= '0;
			wv <= 32'h00000000;
			aw_got <= 1'h0;
			w_got <= 1'h0;
			s_awready <= 1'h1;
			s_wready <= 1'h1;
			s_bvalid <= 1'h0;
			s_bresp <= RESP_OKAY;
			s_arready <= 1'h1;
			s_rvalid <= 1'h0;
			s_rdata <= 32'h00000000;
			s_rresp <= RESP_OKAY;
			tx_reg <= 32'h00000000;
			ctrl <= 9'h000;
			hs <= H_IDLE;
			tick_cnt <= '0;
			bits <= 6'h00;
			tx <= 32'h00000000;
			rx <= 32'h00000000;
			cs_q <= 1'h0;
			sclk_q <= 1'h0;
			sdi_q <= 1'h0;
		end else begin
			wa <= next_wa;
			wv <= next_wv;
			aw_got <= next_aw_got;
			w_got <= next_w_got;
			s_awready <= next_awready;
			s_wready <= next_wready;
			s_bvalid <= next_bvalid;
			s_bresp <= next_bresp;
			s_arready <= next_arready;
			s_rvalid <= next_rvalid;
			s_rdata <= next_rdata;
			s_rresp <= next_rresp;
			tx_reg <= next_tx_reg;
			ctrl <= next_ctrl;
			hs <= next_hs;
			tick_cnt <= next_tick_cnt;
			bits <= next_bits;
			tx <= next_tx;
			rx <= next_rx;
			cs_q <= next_cs;
			sclk_q <= next_sclk;
			sdi_q <= next_sdi;
		end
	end

	assign link.cs = cs_q;
	assign link.sclk = sclk_q;
	assign link.sdi = sdi_q;
endmodule
`default_nettype wire

// File: dv/sec_link_sva.sv
`timescale 1ns/1ns
`default_nettype none
module sec_link_sva #(
	parameter int P16 = 30,
	parameter int PALL = 40
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic cs,
	input wire logic sclk,
	input wire logic sdo_out,
	input wire logic sdo_oe,
	input wire logic busy,
	input wire logic prog_enabled
);
	logic [19:0] bcnt, next_bcnt;
	default clocking @(posedge mclk);
	endclocking
	default disable iff (rst);
	// ----
	// Busy stretch length, judged when it ends
	// ----
	always_comb begin
		next_bcnt = busy ? bcnt + 20'h1 : 20'h0;
	end
	always_ff @(posedge mclk) begin
		bcnt <= rst ? 20'h0 : next_bcnt;
	end
	property p_idle_float;
		(!cs) [*4] |-> !sdo_oe;
	endproperty
	a_idle_float: assert property (p_idle_float)
		else $error("data out driven while deselected");
	property p_oe_rise;
		$rose(sdo_oe) |-> cs && $past(cs);
	endproperty
	a_oe_rise: assert property (p_oe_rise)
		else $error("data out enabled without select");
	property p_busy_status;
		sdo_oe && busy && $past(busy, 3) |-> !sdo_out;
	endproperty
	a_busy_status: assert property (p_busy_status)
		else $error("status not low while busy");
	property p_status_end;
		$fell(sdo_oe) && cs |-> !sclk && $past(sclk, 4);
	endproperty
	a_status_end: assert property (p_status_end)
		else $error("output released off a clock fall");
	property p_read_edge;
		sdo_oe && $changed(sdo_out) && sclk |-> !$past(sclk, 4);
	endproperty
	a_read_edge: assert property (p_read_edge)
		else $error("read bit changed late in high phase");
	property p_dummy;
		$rose(sdo_oe) && sclk |-> !sdo_out;
	endproperty
	a_dummy: assert property (p_dummy)
		else $error("read did not open with a zero");
	property p_busy_cause;
		$rose(busy) |-> !cs && !$past(cs) && ($past(cs, 3) || $past(cs, 4))
			&& prog_enabled;
	endproperty
	a_busy_cause: assert property (p_busy_cause)
		else $error("programming began without select fall");
	property p_locked;
		$fell(cs) && !prog_enabled && !busy |-> !busy [*5];
	endproperty
	a_locked: assert property (p_locked)
		else $error("programming while disabled");
	property p_en_change;
		$changed(prog_enabled) |-> cs && $past(sclk);
	endproperty
	a_en_change: assert property (p_en_change)
		else $error("enable state changed outside a command");
	property p_busy_len;
		$fell(busy) |-> bcnt inside {[P16:P16 + 1], [PALL:PALL + 1]};
	endproperty
	a_busy_len: assert property (p_busy_len)
		else $error("programming time wrong");
endmodule
`default_nettype wire

// File: dv/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
	import sec_pkg::*;
	localparam int P16 = 30;
	localparam int PALL = 40;
	logic mclk, rst, busy, prog_enabled;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rx;
	logic [1:0] bresp, rresp, resp;
	int failures, checked, cycles;
	sec_link_if link ();
	sec_host sec_host_inst (.mclk(mclk), .rst(rst), .s_awaddr(awaddr),
		.s_awvalid(awvalid), .s_awready(awready), .s_wdata(wdata),
		.s_wstrb(4'hF), .s_wvalid(wvalid), .s_wready(wready),
		.s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
		.s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready),
		.s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid),
		.s_rready(rready), .link(link));
	sec_device #(.ADDR_BITS(8), .PROG_X8_CYC(20), .PROG_X16_CYC(P16),
		.PROG_ALL_CYC(PALL)) sec_device_inst (.mclk(mclk), .rst(rst),
		.link(link), .busy(busy), .prog_enabled(prog_enabled));
	sec_link_sva #(.P16(P16), .PALL(PALL)) sec_link_sva_inst (.mclk(mclk),
		.rst(rst), .cs(link.cs), .sclk(link.sclk), .sdo_out(link.sdo_out),
		.sdo_oe(link.sdo_oe), .busy(busy), .prog_enabled(prog_enabled));
	initial begin
		mclk = 1'h0;
		forever #10 mclk = ~mclk;
	end
	// Whole run needs about 12000 cycles
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			failures = failures + 1;
			tally_and_finish();
		end
	end
	task automatic tally_and_finish();
		if (failures == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked = checked + 1;
		if (seen !== exp) begin
			failures = failures + 1;
			$display("Error %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	// ----
	// Bus cycles and link frames
	// ----
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		@(posedge mclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge mclk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
		end while (bvalid !== 1'h1);
		r = bresp;
		bready <= 1'h0;
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge mclk);
			if (arready) arvalid <= 1'h0;
		end while (rvalid !== 1'h1);
		d = rdata;
		r = rresp;
		rready <= 1'h0;
	endtask
	function automatic logic [10:0] c16(input logic [1:0] op,
		input logic [7:0] af);
		return {1'h1, op, af};
	endfunction
	task automatic frame(input logic [31:0] v, input int w, input int n,
		input logic poll);
		logic [31:0] s;
		axi_wr(REG_TXDATA, v << (32 - w), resp);
		axi_wr(REG_CTRL, (32'(poll) << CTRL_POLL_BIT) | 32'(n), resp);
		do axi_rd(REG_STATUS, s, resp);
		while (s[STAT_BUSY_BIT] !== 1'h0);
	endtask
	task automatic rdw(input logic [31:0] v, input int w, input int n,
		output logic [31:0] d);
		frame(v, w, n, 1'h0);
		axi_rd(REG_RXDATA, d, resp);
	endtask
	// Poll frame afterwards waits out the self-timed cycle
	task automatic prog(input logic [31:0] v, input int w, input logic exp);
		frame(v, w, w, 1'h0);
		for (int i = 0; i < 8 && busy !== 1'h1; i++) @(posedge mclk);
		check({31'h0, busy}, {31'h0, exp});
		frame(32'h0, 1, 1, 1'h1);
		check({31'h0, busy}, 32'h0);
	endtask
	// ----
	// Scenarios
	// ----
	task automatic t_bus();
		axi_wr(8'h10, 32'h0, resp);
		check({30'h0, resp}, 32'h2);
		axi_rd(8'h14, rx, resp);
		check({30'h0, resp}, 32'h2);
		check(rx, 32'h0);
	endtask
	task automatic t_powerup();
		check({31'h0, prog_enabled}, 32'h0);
		prog(32'({c16(2'h1, 8'h05), 16'h1111}), 27, 1'h0);
	endtask
	task automatic t_write();
		frame(32'(c16(2'h0, 8'hC0)), 11, 14, 1'h0);
		check({31'h0, prog_enabled}, 32'h1);
		prog(32'({c16(2'h1, 8'h05), 16'hA55A}), 27, 1'h1);
		prog(32'({c16(2'h1, 8'h06), 16'h3C96}), 27, 1'h1);
	endtask
	task automatic t_read();
		rdw(32'(c16(2'h2, 8'h05)), 11, 43, rx);
		check(rx, 32'hA55A3C96);
		// Two idle zero bits ahead of the start bit
		rdw(32'(c16(2'h2, 8'h06)), 13, 29, rx);
		check({14'h0, rx[17:0]}, 32'h23C96);
	endtask
	task automatic t_byte_org();
		link.org_oe <= 1'h1;
		rdw(32'({1'h1, 2'h2, 9'h00A}), 12, 28, rx);
		check({14'h0, rx[17:0]}, 32'h2A55A);
		link.org_oe <= 1'h0;
	endtask
	task automatic t_erase_lock();
		prog(32'(c16(2'h3, 8'h06)), 11, 1'h1);
		frame(32'(c16(2'h0, 8'h00)), 11, 11, 1'h0);
		check({31'h0, prog_enabled}, 32'h0);
		prog(32'({c16(2'h1, 8'h05), 16'h1111}), 27, 1'h0);
		rdw(32'(c16(2'h2, 8'h05)), 11, 43, rx);
		check(rx, 32'hA55AFFFF);
		frame(32'(c16(2'h0, 8'hC0)), 11, 8, 1'h0);
		check({31'h0, prog_enabled}, 32'h0);
	endtask
	task automatic t_all();
		frame(32'(c16(2'h0, 8'hC0)), 11, 11, 1'h0);
		check({31'h0, prog_enabled}, 32'h1);
		prog(32'(c16(2'h0, 8'h80)), 11, 1'h1);
		prog(32'({c16(2'h0, 8'h40), 16'h0FF0}), 27, 1'h1);
		prog(32'({c16(2'h0, 8'h40), 16'h3C3C}), 27, 1'h1);
		rdw(32'(c16(2'h2, 8'h05)), 11, 43, rx);
		check(rx, 32'h0C300C30);
	endtask
	initial begin
		rst = 1'h1;
		awvalid = 1'h0;
		wvalid = 1'h0;
		bready = 1'h0;
		arvalid = 1'h0;
		rready = 1'h0;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		link.org_val = 1'h0;
		link.org_oe = 1'h0;
		repeat (20) @(posedge mclk);
		rst <= 1'h0;
		t_bus();
		t_powerup();
		t_write();
		t_read();
		t_byte_org();
		t_erase_lock();
		t_all();
		tally_and_finish();
	end
endmodule
`default_nettype wire
